// >>> src/hsbc_serial_rate.sv
`timescale 1ns/100ps
`include "hsbc_consts.svh"

// How it works
// - exponent in bits 7..5, mantissa bits 4..0
// - exponent zero: reference divided by mantissa+1
// - else divide by mantissa+33, then 2^(exp-1)
// - frame is start, eight data, stop, no parity
// - rate register resets to 115.2 kbit/s code
module hsbc_serial_rate (
    // clock, reset, freeze
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    // 27.12 mhz reference as a one-cycle tick
    input  wire logic                    ref_tick_i,
    // register access
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire logic [`HSBC_ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    output logic      [7:0]              reg_rdata_o,
    output logic                         reg_rvalid_o,
    // transmit side
    input  wire logic                    tx_valid_i,
    input  wire logic [7:0]              tx_data_i,
    output logic                         tx_ready_o,
    // receive side
    output logic                         rx_valid_o,
    output logic      [7:0]              rx_data_o,
    output logic                         rx_frame_err_o,
    // serial pins
    input  wire logic                    rxd_i,
    output logic                         txd_o
);

    // reference ticks per bit for a given register value
    function automatic logic [`HSBC_DIV_W-1:0] rate_divisor(input hsbc_pkg::hsbc_rate_type r);
        logic [`HSBC_DIV_W-1:0] base;
        base = {8'h00, r.rate_mantissa};
        if (r.rate_exponent == 3'h0) begin
            rate_divisor = base + `HSBC_MANT_OFS_SMALL;
        end else begin
            // largest case is 64 << 6 = 4096, which still fits
            rate_divisor = (base + `HSBC_MANT_OFS_LARGE) << (r.rate_exponent - 3'h1);
        end
    endfunction : rate_divisor

    // register group
    hsbc_pkg::hsbc_rate_type rate_r;        // live rate select
    hsbc_pkg::hsbc_rate_type rate_nxt;
    logic [7:0]              rdata_r;       // read answer
    logic [7:0]              rdata_nxt;
    logic                    rvalid_r;      // read answer strobe
    logic                    rvalid_nxt;

    // transmitter group
    hsbc_pkg::hsbc_tx_state_type tx_state_r;
    hsbc_pkg::hsbc_tx_state_type tx_state_nxt;
    logic [`HSBC_DIV_W-1:0]      tx_div_r;  // divisor frozen for this character
    logic [`HSBC_DIV_W-1:0]      tx_div_nxt;
    logic [`HSBC_DIV_W-1:0]      tx_cnt_r;  // ticks left in current bit
    logic [`HSBC_DIV_W-1:0]      tx_cnt_nxt;
    logic [3:0]                  tx_bits_r; // bits still to send after this one
    logic [3:0]                  tx_bits_nxt;
    logic [8:0]                  tx_sh_r;   // data then stop bit
    logic [8:0]                  tx_sh_nxt;
    logic                        txd_r;
    logic                        txd_nxt;
    logic                        tx_ready_r;
    logic                        tx_ready_nxt;

    // receiver group
    hsbc_pkg::hsbc_rx_state_type rx_state_r;
    hsbc_pkg::hsbc_rx_state_type rx_state_nxt;
    logic [`HSBC_DIV_W-1:0]      rx_div_r;  // divisor frozen for this character
    logic [`HSBC_DIV_W-1:0]      rx_div_nxt;
    logic [`HSBC_DIV_W-1:0]      rx_cnt_r;
    logic [`HSBC_DIV_W-1:0]      rx_cnt_nxt;
    logic [3:0]                  rx_bits_r;
    logic [3:0]                  rx_bits_nxt;
    logic [7:0]                  rx_sh_r;
    logic [7:0]                  rx_sh_nxt;
    logic [7:0]                  rx_data_r;
    logic [7:0]                  rx_data_nxt;
    logic                        rx_valid_r;
    logic                        rx_valid_nxt;
    logic                        rx_ferr_r;
    logic                        rx_ferr_nxt;

    logic                        reg_hit;   // access aimed at the rate register
    logic [`HSBC_DIV_W-1:0]      cur_div;   // divisor of the live setting

    assign reg_hit = (reg_addr_i == `HSBC_RATE_ADDR);
    assign cur_div = rate_divisor(rate_r);

    // register next values; other addresses read as zero
    always_comb begin
        rate_nxt   = rate_r;
        rdata_nxt  = 8'h00;
        rvalid_nxt = reg_rd_i;
        if (reg_wr_i && reg_hit) begin
            rate_nxt = reg_wdata_i;
        end
        if (reg_rd_i && reg_hit) begin
            rdata_nxt = rate_r;
        end
    end

    // register flops
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rate_r   <= `HSBC_RATE_RESET;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else if (ce_i) begin
            rate_r   <= rate_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // transmitter next values
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_div_nxt   = tx_div_r;
        tx_cnt_nxt   = tx_cnt_r;
        tx_bits_nxt  = tx_bits_r;
        tx_sh_nxt    = tx_sh_r;
        txd_nxt      = txd_r;
        tx_ready_nxt = tx_ready_r;
        unique case (tx_state_r)
            hsbc_pkg::HSBC_TX_IDLE: begin
                if (tx_valid_i && tx_ready_r) begin
                    // latch the rate now so a later write cannot stretch this character
                    tx_div_nxt   = cur_div;
                    tx_cnt_nxt   = cur_div - 13'h0001;
                    tx_sh_nxt    = {1'b1, tx_data_i};
                    tx_bits_nxt  = `HSBC_TX_BITS_LEFT;
                    txd_nxt      = 1'b0;
                    tx_ready_nxt = 1'b0;
                    tx_state_nxt = hsbc_pkg::HSBC_TX_SHIFT;
                end
            end
            hsbc_pkg::HSBC_TX_SHIFT: begin
                if (ref_tick_i) begin
                    if (tx_cnt_r != '0) begin
                        tx_cnt_nxt = tx_cnt_r - 13'h0001;
                    end else if (tx_bits_r == 4'h0) begin
                        // stop bit has run its full length
                        txd_nxt      = 1'b1;
                        tx_ready_nxt = 1'b1;
                        tx_state_nxt = hsbc_pkg::HSBC_TX_IDLE;
                    end else begin
                        txd_nxt     = tx_sh_r[0];
                        tx_sh_nxt   = {1'b1, tx_sh_r[8:1]};
                        tx_bits_nxt = tx_bits_r - 4'h1;
                        tx_cnt_nxt  = tx_div_r - 13'h0001;
                    end
                end
            end
        endcase
    end

    // transmitter flops; line idles high
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_state_r <= hsbc_pkg::HSBC_TX_IDLE;
            tx_div_r   <= '0;
            tx_cnt_r   <= '0;
            tx_bits_r  <= 4'h0;
            tx_sh_r    <= 9'h1ff;
            txd_r      <= 1'b1;
            tx_ready_r <= 1'b1;
        end else if (ce_i) begin
            tx_state_r <= tx_state_nxt;
            tx_div_r   <= tx_div_nxt;
            tx_cnt_r   <= tx_cnt_nxt;
            tx_bits_r  <= tx_bits_nxt;
            tx_sh_r    <= tx_sh_nxt;
            txd_r      <= txd_nxt;
            tx_ready_r <= tx_ready_nxt;
        end
    end

    // receiver next values; samples mid-bit, no oversampling vote
    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_div_nxt   = rx_div_r;
        rx_cnt_nxt   = rx_cnt_r;
        rx_bits_nxt  = rx_bits_r;
        rx_sh_nxt    = rx_sh_r;
        rx_data_nxt  = rx_data_r;
        rx_valid_nxt = 1'b0;
        rx_ferr_nxt  = rx_ferr_r;
        unique case (rx_state_r)
            hsbc_pkg::HSBC_RX_IDLE: begin
                if (!rxd_i) begin
                    // a low line seen in idle opens a character at the rate valid right now
                    rx_div_nxt   = cur_div;
                    rx_cnt_nxt   = cur_div >> 1;
                    rx_state_nxt = hsbc_pkg::HSBC_RX_START;
                end
            end
            hsbc_pkg::HSBC_RX_START: begin
                if (ref_tick_i) begin
                    if (rx_cnt_r != '0) begin
                        rx_cnt_nxt = rx_cnt_r - 13'h0001;
                    end else if (!rxd_i) begin
                        // start bit still low at its middle
                        rx_cnt_nxt   = rx_div_r - 13'h0001;
                        rx_bits_nxt  = `HSBC_DATA_BITS;
                        rx_state_nxt = hsbc_pkg::HSBC_RX_DATA;
                    end else begin
                        // glitch, not a start bit
                        rx_state_nxt = hsbc_pkg::HSBC_RX_IDLE;
                    end
                end
            end
            hsbc_pkg::HSBC_RX_DATA: begin
                if (ref_tick_i) begin
                    if (rx_cnt_r != '0) begin
                        rx_cnt_nxt = rx_cnt_r - 13'h0001;
                    end else begin
                        rx_sh_nxt   = {rxd_i, rx_sh_r[7:1]};
                        rx_bits_nxt = rx_bits_r - 4'h1;
                        rx_cnt_nxt  = rx_div_r - 13'h0001;
                        if (rx_bits_r == 4'h1) begin
                            rx_state_nxt = hsbc_pkg::HSBC_RX_STOP;
                        end
                    end
                end
            end
            hsbc_pkg::HSBC_RX_STOP: begin
                if (ref_tick_i) begin
                    if (rx_cnt_r != '0) begin
                        rx_cnt_nxt = rx_cnt_r - 13'h0001;
                    end else begin
                        // no parity; a low stop bit is reported, data still delivered
                        rx_data_nxt  = rx_sh_r;
                        rx_valid_nxt = 1'b1;
                        rx_ferr_nxt  = ~rxd_i;
                        rx_state_nxt = hsbc_pkg::HSBC_RX_IDLE;
                    end
                end
            end
        endcase
    end

    // receiver flops
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx_state_r <= hsbc_pkg::HSBC_RX_IDLE;
            rx_div_r   <= '0;
            rx_cnt_r   <= '0;
            rx_bits_r  <= 4'h0;
            rx_sh_r    <= 8'h00;
            rx_data_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_ferr_r  <= 1'b0;
        end else if (ce_i) begin
            rx_state_r <= rx_state_nxt;
            rx_div_r   <= rx_div_nxt;
            rx_cnt_r   <= rx_cnt_nxt;
            rx_bits_r  <= rx_bits_nxt;
            rx_sh_r    <= rx_sh_nxt;
            rx_data_r  <= rx_data_nxt;
            rx_valid_r <= rx_valid_nxt;
            rx_ferr_r  <= rx_ferr_nxt;
        end
    end

    // every output straight from a flop
    assign reg_rdata_o    = rdata_r;
    assign reg_rvalid_o   = rvalid_r;
    assign tx_ready_o     = tx_ready_r;
    assign txd_o          = txd_r;
    assign rx_valid_o     = rx_valid_r;
    assign rx_data_o      = rx_data_r;
    assign rx_frame_err_o = rx_ferr_r;

endmodule : hsbc_serial_rate

// >>> src/hsbc_consts.svh
`ifndef HSBC_CONSTS_SVH
`define HSBC_CONSTS_SVH

// register map of the serial rate block
`define HSBC_ADDR_W          8
`define HSBC_RATE_ADDR       8'h3b
`define HSBC_RATE_RESET      8'h7a

// field layout of the rate select register
`define HSBC_EXP_MSB         7
`define HSBC_EXP_LSB         5
`define HSBC_MANT_MSB        4
`define HSBC_MANT_LSB        0

// divider arithmetic, counted in reference ticks
`define HSBC_REF_KHZ         27120
`define HSBC_DIV_W           13
`define HSBC_MANT_OFS_SMALL  13'h0001
`define HSBC_MANT_OFS_LARGE  13'h0021

// character framing: start, eight data, stop
`define HSBC_DATA_BITS       4'h8
`define HSBC_TX_BITS_LEFT    4'h9

`endif

// >>> src/hsbc_pkg.sv
`include "hsbc_consts.svh"

package hsbc_pkg;

    // rate select register split into its two fields
    typedef struct packed {
        logic [`HSBC_EXP_MSB-`HSBC_EXP_LSB:0]   rate_exponent;
        logic [`HSBC_MANT_MSB-`HSBC_MANT_LSB:0] rate_mantissa;
    } hsbc_rate_type;

    // transmitter states
    typedef enum logic [0:0] {
        HSBC_TX_IDLE,
        HSBC_TX_SHIFT
    } hsbc_tx_state_type;

    // receiver states
    typedef enum logic [1:0] {
        HSBC_RX_IDLE,
        HSBC_RX_START,
        HSBC_RX_DATA,
        HSBC_RX_STOP
    } hsbc_rx_state_type;

endpackage : hsbc_pkg

// >>> verif/hsbc_serial_rate_properties.sv
`timescale 1ns/100ps
`include "hsbc_consts.svh"
module hsbc_serial_rate_properties (
    // clock, reset, freeze
    input wire logic                    mclk_i,
    input wire logic                    rst_n_i,
    input wire logic                    ce_i,
    // register access
    input wire logic                    reg_wr_i,
    input wire logic                    reg_rd_i,
    input wire logic [`HSBC_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]              reg_wdata_i,
    input wire logic [7:0]              reg_rdata_o,
    input wire logic                    reg_rvalid_o,
    // serial streams
    input wire logic                    tx_valid_i,
    input wire logic                    tx_ready_o,
    input wire logic                    rx_valid_o,
    input wire logic                    txd_o
);
    logic [7:0] rate_m_r;   // shadow of the rate register
    logic [7:0] rate_m_nxt; // its next value
    // shadow follows writes to the one mapped address
    always_comb begin
        rate_m_nxt = rate_m_r;
        if (reg_wr_i && reg_addr_i == `HSBC_RATE_ADDR) begin
            rate_m_nxt = reg_wdata_i;
        end
    end
    // shadow resets like the design: reset does not wait for ce_i, writes do
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rate_m_r <= `HSBC_RATE_RESET;
        end else if (ce_i) begin
            rate_m_r <= rate_m_nxt;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_take;
        tx_valid_i && tx_ready_o && ce_i;
    endsequence
    sequence s_start;
        !txd_o && !tx_ready_o;
    endsequence
    a_tx_start: assert property (s_take |=> s_start)
        else $error("start bit missing after byte taken");
    a_tx_busy: assert property (s_take |=> !tx_ready_o [*8])
        else $error("transmitter ready too early");
    a_line_idle: assert property (tx_ready_o |-> txd_o)
        else $error("serial line low while idle");
    a_rate_read: assert property (reg_rd_i && ce_i && reg_addr_i == `HSBC_RATE_ADDR
        |=> reg_rdata_o == $past(rate_m_r))
        else $error("rate register read wrong");
    a_miss_zero: assert property (reg_rd_i && ce_i && reg_addr_i != `HSBC_RATE_ADDR
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rd_valid: assert property (reg_rd_i && ce_i |=> reg_rvalid_o)
        else $error("read valid missing");
    a_rd_quiet: assert property (!reg_rd_i && ce_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
        else $error("read data without read");
    a_rx_single: assert property (rx_valid_o && ce_i |=> !rx_valid_o)
        else $error("receive valid longer than one cycle");
endmodule : hsbc_serial_rate_properties
bind hsbc_serial_rate hsbc_serial_rate_properties i_hsbc_serial_rate_properties (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_valid_o(rx_valid_o), .txd_o(txd_o));

// >>> verif/hsbc_host_model.sv
`timescale 1ns/100ps
module hsbc_host_model (
    // clock and reference tick
    input  wire logic ref_tick_i,
    input  wire logic mclk_i,
    // serial lines seen from the host
    input  wire logic txd_i,
    output logic      rxd_o
);
    int         div = 236;   // ticks per bit, set by the bench
    int         got_cnt = 0; // characters decoded
    logic [7:0] got_data;    // last decoded byte
    logic       got_stop;    // last stop bit level
    initial rxd_o = 1'b1;    // line idles high between frames
    // count ticks the way the device samples them
    task automatic ticks(input int n);
        int k;
        k = 0;
        while (k < n) begin
            @(posedge mclk_i);
            if (ref_tick_i) k++;
        end
    endtask : ticks
    // one frame, lsb first; a low stop bit provokes a framing fault
    task automatic send(input logic [7:0] b, input logic stop);
        rxd_o <= 1'b0;
        ticks(div);
        for (int i = 0; i < 8; i++) begin
            rxd_o <= b[i];
            ticks(div);
        end
        rxd_o <= stop;
        ticks(div);
        rxd_o <= 1'b1;
    endtask : send
    // decoder samples each bit in its middle, no oversampling
    always begin
        @(posedge mclk_i);
        if (!txd_i) begin
            ticks(div / 2);
            for (int i = 0; i < 8; i++) begin
                ticks(div);
                got_data[i] = txd_i;
            end
            ticks(div);
            got_stop = txd_i;
            got_cnt++;
        end
    end
endmodule : hsbc_host_model

// >>> verif/test_hsbc_serial_rate.sv
`timescale 1ns/100ps
`include "hsbc_consts.svh"
module test_hsbc_serial_rate;
    logic       mclk_i, rst_n_i, ce_i, ref_tick_i, reg_wr_i, reg_rd_i, tx_valid_i, rxd_i;
    logic [7:0] reg_addr_i, reg_wdata_i, tx_data_i, reg_rdata_o, rx_data_o, code;
    logic       reg_rvalid_o, tx_ready_o, rx_valid_o, rx_frame_err_o, txd_o;
    int         num_errors = 0;
    int         checked = 0;
    int         e, m;
    logic [7:0] codes [4] = '{8'h15, 8'h1c, 8'h3a, 8'h7a}; // fastest, standard and default codes
    hsbc_serial_rate i_hsbc_serial_rate (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .ref_tick_i(ref_tick_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
        .rx_data_o(rx_data_o), .rx_frame_err_o(rx_frame_err_o), .rxd_i(rxd_i), .txd_o(txd_o));
    hsbc_host_model i_hsbc_host_model (.ref_tick_i(ref_tick_i), .mclk_i(mclk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // reference tick every other cycle keeps the run short
    always @(posedge mclk_i) ref_tick_i <= ~ref_tick_i;
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task final_report();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // reference ticks per bit for a register code
    function int exp_div(input logic [7:0] c);
        hsbc_pkg::hsbc_rate_type r;
        r = c;
        if (r.rate_exponent == 3'h0) return int'(r.rate_mantissa) + 1;
        return (int'(r.rate_mantissa) + 33) << (int'(r.rate_exponent) - 1);
    endfunction : exp_div
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        check("rdata", reg_rdata_o, exp);
        check("rvalid", reg_rvalid_o, 1'b1);
    endtask : rd_chk
    // byte out, frame length in ticks compared with ten bit times
    task tx_chk(input logic [7:0] b, input int d);
        int cnt, n0, k;
        n0 = i_hsbc_host_model.got_cnt;
        cnt = 0;
        k = 0;
        // offer the byte on a rising edge, hold it until the edge that takes it
        @(posedge mclk_i);
        tx_valid_i <= 1'b1;
        tx_data_i  <= b;
        do begin @(posedge mclk_i); k++; end while (!tx_ready_o && k < 100);
        if (!tx_ready_o) begin num_errors++; final_report(); end
        tx_valid_i <= 1'b0;
        k = 0;
        do begin @(posedge mclk_i); k++; if (ref_tick_i) cnt++; end while (!tx_ready_o && k < 60000);
        if (k >= 60000) begin num_errors++; final_report(); end
        check("tx length", (cnt >= 10 * d - 2) && (cnt <= 10 * d + 2), 1'b1);
        check("tx byte", i_hsbc_host_model.got_data, b);
        check("tx stop", i_hsbc_host_model.got_stop, 1'b1);
        check("tx count", 16'(i_hsbc_host_model.got_cnt - n0), 16'h0001);
    endtask : tx_chk
    task rx_chk(input logic [7:0] b, input logic stop);
        int k;
        fork
            i_hsbc_host_model.send(b, stop);
            for (k = 0; k < 60000; k++) begin @(posedge mclk_i); #1; if (rx_valid_o) break; end
        join
        if (k >= 60000) begin num_errors++; final_report(); end
        check("rx byte", rx_data_o, b);
        check("rx frame err", rx_frame_err_o, !stop);
    endtask : rx_chk
    initial begin
        {rst_n_i, ref_tick_i, reg_wr_i, reg_rd_i, tx_valid_i} = 5'h00;
        {reg_addr_i, reg_wdata_i, tx_data_i} = 24'h000000;
        ce_i = 1'b1;
        void'($urandom(35900));
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd_chk(8'h3b, 8'h7a);
        wr(8'h3c, 8'h55);
        rd_chk(8'h3c, 8'h00);
        rd_chk(8'h3b, 8'h7a);
        // rate change in mid character must wait for the next one
        fork
            tx_chk(8'ha5, exp_div(8'h7a));
            begin repeat (300) @(posedge mclk_i); wr(8'h3b, 8'h15); end
        join
        i_hsbc_host_model.div = exp_div(8'h15);
        tx_chk(8'h3c, exp_div(8'h15));
        for (int i = 0; i < 7; i++) begin
            e = $urandom_range(0, 2);
            m = (e == 0) ? $urandom_range(21, 31) : $urandom_range(0, 31);
            code = (i < 4) ? codes[i] : {e[2:0], m[4:0]};
            wr(8'h3b, code);
            rd_chk(8'h3b, code);
            i_hsbc_host_model.div = exp_div(code);
            tx_chk(8'($urandom), exp_div(code));
            rx_chk(8'($urandom), i != 0);
        end
        // a write while the clock enable is low must not land
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(8'h3b, 8'heb);
        ce_i <= 1'b1;
        rd_chk(8'h3b, code);
        // second reset in mid run brings back the default rate
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd_chk(8'h3b, 8'h7a);
        final_report();
    end
endmodule : test_hsbc_serial_rate
